/* File: i2cerr_top.sv */
/*
  Two-wire interface error handling: slave access errors, boot
  loader errors, and the AHB-Lite register slave for interrupts.
  Assumes the serial engine and loader sequencer run on hclk.
*/
// Functional notes
// (R01) Missing register block: read zero, drop write
// (R02) Access disabled: use remote data registers only
// (R03) Slave timeouts release lines, wait, flag
// (R04) Driven one sensed zero is a collision
// (R05) Six unacknowledged EEPROM reads abort the load
// (R06) Oversized image count aborts with size error
// (R07) Records to missing registers dropped silently
// (R08) Arbitration not won before timer: abort
// (R09) Protocol error or bad count byte aborts
// (R10) Enabled status bits drive the interrupt
// (R11) Write-one clears only after a status read
// (R12) Set register raises status for test
// (R13) Events after the read keep status set
// (R14) Status read snapshots new events
`default_nettype none
module i2cerr_top #(
  parameter int BOOT_TMO_CYCLES = 1000000
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  // Serial pins, open drain
  input  wire logic        scl_in,
  input  wire logic        serial_data_line_in,
  output logic             scl_oe,
  output logic             serial_data_line_oe,
  // Slave engine
  input  wire logic        slv_active,
  input  wire logic        slv_byte_active,
  input  wire logic        slv_drive_phase,
  input  wire logic        slv_sda_low,
  input  wire logic        slv_scl_hold,
  input  wire logic        slv_req,
  input  wire logic        slv_we,
  input  wire logic [15:0] slv_addr,
  input  wire logic [31:0] slv_wdata,
  output logic             slv_rsp_valid,
  output logic [31:0]      slv_rsp_rdata,
  output logic             slv_wait,
  // Internal register port
  output logic             int_req,
  output logic             int_we,
  output logic [15:0]      int_addr,
  output logic [31:0]      int_wdata,
  input  wire logic        int_ack,
  input  wire logic [31:0] int_rdata,
  // Boot loader sequencer
  input  wire logic        bl_start,
  input  wire logic        bl_arb_won,
  input  wire logic        bl_nack,
  input  wire logic        bl_size_valid,
  input  wire logic [15:0] bl_size,
  input  wire logic        bl_two_byte,
  input  wire logic        bl_cnt_valid,
  input  wire logic [2:0]  bl_cnt_idx,
  input  wire logic [7:0]  bl_cnt_byte,
  input  wire logic        bl_proto_err,
  input  wire logic        bl_rec_valid,
  input  wire logic [15:0] bl_rec_addr,
  input  wire logic [31:0] bl_rec_data,
  input  wire logic        bl_done,
  output logic             bl_retry,
  output logic             bl_abort,
  output logic             init_we,
  output logic [15:0]      init_addr,
  output logic [31:0]      init_data
);
  import i2cerr_pkg::*;

  typedef struct packed {
    logic            dp_wr;     // Write data phase pending
    logic [7:0]      dp_addr;   // Latched write offset
    logic [31:0]     hrdata;    // Read data for the data phase
    logic            int_ena;   // Internal access enable
    logic [31:0]     rdata_reg; // Remote read data register
    logic [31:0]     wdata_reg; // Remote write data register
    logic [TO_W-1:0] to_low;    // Clock-low limit, cycles
    logic [TO_W-1:0] to_byte;   // Byte limit, cycles
    logic [TO_W-1:0] to_trn;    // Transaction limit, cycles
    logic [TO_W-1:0] cnt_low;
    logic [TO_W-1:0] cnt_byte;
    logic [TO_W-1:0] cnt_trn;
    logic            scl_q;     // Previous synced clock
    logic            sda_q;     // Previous synced data
    logic            wait_st;   // Slave parked after a failure
    logic            sda_oe;
    logic            scl_oe;
    logic            pend;      // Internal access outstanding
    logic            rsp_v;
    logic [31:0]     rsp_d;
    logic            int_req;
    logic            int_we;
    logic [15:0]     int_addr;
    logic [31:0]     int_wd;
    i2cerr_ld_type   ld;        // Loader state
    logic [2:0]      tries;     // Unacknowledged attempts
    logic [31:0]     ld_tmr;    // Boot arbitration timer
    logic            retry;
    logic            abort;
    logic            init_we;
    logic [15:0]     init_addr;
    logic [31:0]     init_d;
    logic [NEV-1:0]  evt;       // Event pulses to the irq unit
  } i2cerr_st_type;

  localparam logic [31:0] BOOT_LAST = 32'(BOOT_TMO_CYCLES - 1);

  i2cerr_st_type st_r, st_nxt;
  i2cerr_evt_if  eb ();
  logic          scl_s;        // Synced clock pin
  logic          sda_s;        // Synced data pin
  logic          addr_ph;      // AHB address phase accepted
  logic          to_low_hit;
  logic          to_byte_hit;
  logic          to_trn_hit;
  logic          coll;
  logic          cnt_bad;
  logic          sz_bad;
  logic [31:0]   rd_mux;

  // Pins cross into hclk through two flops each
  i2cerr_sync #(.W(2)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({scl_in, serial_data_line_in}),
    .q       ({scl_s, sda_s})
  );

  // Event, snapshot and status logic
  i2cerr_irq u_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .b       (eb.intr)
  );

  // Read mux, decoded on the address phase offset
  always_comb begin
    unique case (haddr[7:0])
      A_CTRL:  rd_mux = {31'h0, st_r.int_ena};
      A_STAT:  rd_mux = {{(32-NST){1'b0}}, eb.status};
      A_INTEN: rd_mux = {{(32-NST){1'b0}}, eb.int_en};
      A_EVEN:  rd_mux = {{(32-NEV){1'b0}}, eb.evt_en};
      A_EVT:   rd_mux = {{(32-NEV){1'b0}}, eb.event_v};
      A_RDATA: rd_mux = st_r.rdata_reg;
      A_WDATA: rd_mux = st_r.wdata_reg;
      A_STATE: rd_mux = {24'h0, st_r.tries, st_r.ld,
                         st_r.pend, st_r.wait_st};
      A_TLOW:  rd_mux = {16'h0, st_r.to_low};
      A_TBYTE: rd_mux = {16'h0, st_r.to_byte};
      A_TTRN:  rd_mux = {16'h0, st_r.to_trn};
      // Unmapped offsets and the write-only set register read zero
      default: rd_mux = 32'h0;
    endcase
  end

  // Register strobes for the interrupt unit
  always_comb begin
    addr_ph     = hsel && hready && htrans[1];
    eb.stat_rd  = addr_ph && !hwrite && (haddr[7:0] == A_STAT);
    eb.stat_wr  = st_r.dp_wr && (st_r.dp_addr == A_STAT);
    eb.set_wr   = st_r.dp_wr && (st_r.dp_addr == A_ISET);
    eb.inten_wr = st_r.dp_wr && (st_r.dp_addr == A_INTEN);
    eb.evten_wr = st_r.dp_wr && (st_r.dp_addr == A_EVEN);
    eb.evt_wr   = st_r.dp_wr && (st_r.dp_addr == A_EVT);
    eb.wdata    = hwdata;
    eb.evt      = st_r.evt;
  end

  // Error detectors on the slave side and in the loader
  always_comb begin
    to_low_hit  = (st_r.to_low != '0) && (st_r.cnt_low == st_r.to_low);
    to_byte_hit = (st_r.to_byte != '0) && (st_r.cnt_byte == st_r.to_byte);
    to_trn_hit  = (st_r.to_trn != '0) && (st_r.cnt_trn == st_r.to_trn);
    // Released line read low on our own rising clock edge
    coll = slv_drive_phase && !slv_sda_low && scl_s && !st_r.scl_q
           && !sda_s;                                         // R04
    cnt_bad = bl_cnt_valid && (bl_cnt_idx >= CNT_LO)
              && (bl_cnt_idx <= CNT_HI) && (bl_cnt_byte != CNT_FILL); // R09
    sz_bad = bl_size_valid && (bl_two_byte ? (bl_size > SZ2_MAX)
                                           : (bl_size > SZ1_MAX)); // R06
  end

  // Next-state logic for bus, slave and loader
  always_comb begin
    st_nxt         = st_r;
    st_nxt.evt     = '0;
    st_nxt.rsp_v   = 1'b0;
    st_nxt.retry   = 1'b0;
    st_nxt.abort   = 1'b0;
    st_nxt.init_we = 1'b0;
    st_nxt.dp_wr   = 1'b0;
    st_nxt.scl_q   = scl_s;
    st_nxt.sda_q   = sda_s;

    // AHB address phase: zero wait, read data ready next cycle
    if (addr_ph) begin
      st_nxt.dp_wr   = hwrite;
      st_nxt.dp_addr = haddr[7:0];
      st_nxt.hrdata  = hwrite ? 32'h0 : rd_mux;
    end
    // AHB data phase for own registers
    if (st_r.dp_wr) begin
      unique case (st_r.dp_addr)
        A_CTRL:  st_nxt.int_ena   = hwdata[0];
        A_RDATA: st_nxt.rdata_reg = hwdata;
        A_WDATA: st_nxt.wdata_reg = hwdata;
        A_TLOW:  st_nxt.to_low    = hwdata[TO_W-1:0];
        A_TBYTE: st_nxt.to_byte   = hwdata[TO_W-1:0];
        A_TTRN:  st_nxt.to_trn    = hwdata[TO_W-1:0];
        // Interrupt unit registers and holes need nothing here
        default: st_nxt.int_ena   = st_r.int_ena;
      endcase
    end

    // Timeout counters; they only run while the slave is live
    st_nxt.cnt_low  = (slv_active && !scl_s && !st_r.wait_st)
                      ? st_r.cnt_low + 1'b1 : '0;
    st_nxt.cnt_byte = (slv_byte_active && !st_r.wait_st)
                      ? st_r.cnt_byte + 1'b1 : '0;
    st_nxt.cnt_trn  = (slv_active && !st_r.wait_st)
                      ? st_r.cnt_trn + 1'b1 : '0;

    // Park on any failure; only a STOP on the bus frees us
    if (!st_r.wait_st) begin
      if (to_low_hit || to_byte_hit || to_trn_hit || coll) begin
        st_nxt.wait_st = 1'b1; // R03 R04
        st_nxt.evt[EV_CLKLOW] = to_low_hit; // R03
        st_nxt.evt[EV_BYTETO] = to_byte_hit; // R03
        st_nxt.evt[EV_TRNTO]  = to_trn_hit; // R03
        st_nxt.evt[EV_COLL]   = coll; // R04
      end
    end else if (scl_s && sda_s && !st_r.sda_q) begin
      st_nxt.wait_st = 1'b0;
    end
    // Both lines let go while parked
    st_nxt.sda_oe = slv_sda_low && !st_nxt.wait_st; // R03 R04
    st_nxt.scl_oe = slv_scl_hold && !st_nxt.wait_st; // R03 R04

    // Slave register access request from the engine
    if (slv_req && !st_r.pend && !st_r.wait_st) begin
      if (!st_r.int_ena) begin
        // Remote data registers only; done event still raised
        st_nxt.rsp_v = 1'b1; // R02
        st_nxt.rsp_d = st_r.rdata_reg; // R02
        if (slv_we) st_nxt.wdata_reg = slv_wdata; // R02
        st_nxt.evt[EV_DONE] = 1'b1; // R02
      end else if (slv_addr[15:12] >= BLK_COUNT) begin
        st_nxt.rsp_v = 1'b1; // R01
        st_nxt.rsp_d = 32'h0; // R01
        st_nxt.evt[EV_DONE] = 1'b1; // R01
      end else begin
        st_nxt.pend     = 1'b1;
        st_nxt.int_req  = 1'b1;
        st_nxt.int_we   = slv_we;
        st_nxt.int_addr = slv_addr;
        st_nxt.int_wd   = slv_wdata;
        if (slv_we) st_nxt.wdata_reg = slv_wdata;
      end
    end
    // Internal register answer completes the access
    if (st_r.pend && int_ack) begin
      st_nxt.pend    = 1'b0;
      st_nxt.int_req = 1'b0;
      st_nxt.rsp_v   = 1'b1;
      st_nxt.rsp_d   = st_r.int_we ? 32'h0 : int_rdata;
      if (!st_r.int_we) st_nxt.rdata_reg = int_rdata;
      st_nxt.evt[EV_RDONE] = !st_r.int_we;
      st_nxt.evt[EV_WDONE] = st_r.int_we;
      st_nxt.evt[EV_DONE]  = 1'b1;
    end

    // Boot loader supervision
    unique case (st_r.ld)
      LD_IDLE, LD_END, LD_ABORT: begin
        if (bl_start) begin
          st_nxt.ld     = LD_ARB;
          st_nxt.ld_tmr = 32'h0;
          st_nxt.tries  = 3'h0;
        end
      end
      LD_ARB: begin
        if (bl_arb_won) begin
          st_nxt.ld = LD_RUN;
        end else if (st_r.ld_tmr == BOOT_LAST) begin
          st_nxt.ld = LD_ABORT; // R08
          st_nxt.abort = 1'b1; // R08
          st_nxt.evt[EV_BOOTTO] = 1'b1; // R08
        end else begin
          st_nxt.ld_tmr = st_r.ld_tmr + 1'b1;
        end
      end
      LD_RUN: begin
        if (bl_proto_err || cnt_bad) begin
          st_nxt.ld = LD_ABORT; // R09
          st_nxt.abort = 1'b1; // R09
          st_nxt.evt[EV_PROTO] = 1'b1; // R09
        end else if (sz_bad) begin
          st_nxt.ld = LD_ABORT; // R06
          st_nxt.abort = 1'b1; // R06
          st_nxt.evt[EV_SIZE] = 1'b1; // R06
        end else if (bl_nack) begin
          // The sixth refusal ends the load; earlier ones retry
          if (st_r.tries == MAX_TRIES - 3'h1) begin
            st_nxt.ld = LD_ABORT; // R05
            st_nxt.abort = 1'b1; // R05
            st_nxt.evt[EV_NODEV] = 1'b1; // R05
          end else begin
            st_nxt.tries = st_r.tries + 3'h1; // R05
            st_nxt.retry = 1'b1; // R05
          end
        end else if (bl_rec_valid) begin
          // Missing registers swallow the record, no event
          if (bl_rec_addr[15:12] < BLK_COUNT) begin // R07
            st_nxt.init_we   = 1'b1;
            st_nxt.init_addr = bl_rec_addr;
            st_nxt.init_d    = bl_rec_data;
          end
        end else if (bl_done) begin
          st_nxt.ld = LD_END;
        end
      end
      default: st_nxt.ld = LD_IDLE;
    endcase
  end

  // State register; non-zero reset fields set one by one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r         <= '0;
      st_r.int_ena <= 1'b1;
      st_r.to_low  <= TO_RST;
      st_r.to_byte <= TO_RST;
      st_r.to_trn  <= TO_RST;
      st_r.scl_q   <= 1'b1;
      st_r.sda_q   <= 1'b1;
      st_r.ld      <= LD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops; hreadyout and hresp tied off
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = st_r.hrdata;
  assign irq                 = eb.irq;
  assign scl_oe              = st_r.scl_oe;
  assign serial_data_line_oe = st_r.sda_oe;
  assign slv_rsp_valid       = st_r.rsp_v;
  assign slv_rsp_rdata       = st_r.rsp_d;
  assign slv_wait            = st_r.wait_st;
  assign int_req             = st_r.int_req;
  assign int_we              = st_r.int_we;
  assign int_addr            = st_r.int_addr;
  assign int_wdata           = st_r.int_wd;
  assign bl_retry            = st_r.retry;
  assign bl_abort            = st_r.abort;
  assign init_we             = st_r.init_we;
  assign init_addr           = st_r.init_addr;
  assign init_data           = st_r.init_d;
endmodule // i2cerr_top
`default_nettype wire

/* File: i2cerr_pkg.sv */
/*
  Shared constants for the two-wire error and interrupt block:
  register offsets, event and status bit positions, limits.
  Assumes a 32-bit AHB-Lite register bus and a 100 MHz core clock.
*/
`default_nettype none
package i2cerr_pkg;
  // Event vector layout
  localparam int NEV       = 11;
  localparam int NST       = 5;
  localparam int EV_DONE   = 0;   // Slave transaction done
  localparam int EV_RDONE  = 1;   // Internal read done
  localparam int EV_WDONE  = 2;   // Internal write done
  localparam int EV_CLKLOW = 3;   // Clock-low timeout
  localparam int EV_BYTETO = 4;   // Byte timeout
  localparam int EV_TRNTO  = 5;   // Transaction timeout
  localparam int EV_COLL   = 6;   // Collision
  localparam int EV_NODEV  = 7;   // Boot: no device
  localparam int EV_SIZE   = 8;   // Boot: size error
  localparam int EV_BOOTTO = 9;   // Boot: arbitration timeout
  localparam int EV_PROTO  = 10;  // Boot: protocol error
  // Status bit to related events, status 4 down to 0
  localparam logic [NST-1:0][NEV-1:0] EV_MAP =
    {11'h780, 11'h078, 11'h004, 11'h002, 11'h001};
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_INTEN = 8'h08;
  localparam logic [7:0] A_ISET  = 8'h0C;
  localparam logic [7:0] A_EVEN  = 8'h10;
  localparam logic [7:0] A_EVT   = 8'h14;
  localparam logic [7:0] A_RDATA = 8'h18;
  localparam logic [7:0] A_WDATA = 8'h1C;
  localparam logic [7:0] A_STATE = 8'h20;
  localparam logic [7:0] A_TLOW  = 8'h24;
  localparam logic [7:0] A_TBYTE = 8'h28;
  localparam logic [7:0] A_TTRN  = 8'h2C;
  // Limits and reset values
  localparam int          TO_W      = 16;
  localparam logic [15:0] TO_RST    = 16'hFFFF;
  localparam logic [3:0]  BLK_COUNT = 4'h4;
  localparam logic [2:0]  MAX_TRIES = 3'h6;
  localparam logic [15:0] SZ1_MAX   = 16'h00FF;
  localparam logic [15:0] SZ2_MAX   = 16'h1FFF;
  localparam logic [7:0]  CNT_FILL  = 8'hFF;
  localparam logic [2:0]  CNT_LO    = 3'h2;
  localparam logic [2:0]  CNT_HI    = 3'h7;
  // Loader states
  typedef enum logic [2:0] {
    LD_IDLE  = 3'b000,
    LD_ARB   = 3'b001,
    LD_RUN   = 3'b010,
    LD_END   = 3'b011,
    LD_ABORT = 3'b100
  } i2cerr_ld_type;
endpackage
`default_nettype wire

/* File: i2cerr_evt_if.sv */
/*
  Event and register-strobe bundle between the core and the
  interrupt unit. Both ends sit on hclk.
*/
`default_nettype none
interface i2cerr_evt_if;
  import i2cerr_pkg::*;
  logic [NEV-1:0] evt;      // One-cycle event pulses
  logic           stat_rd;  // Status register read
  logic           stat_wr;  // Status write-1-to-clear
  logic           set_wr;   // Test set register write
  logic           inten_wr; // Interrupt enable write
  logic           evten_wr; // Event enable write
  logic           evt_wr;   // Event register write-1-to-clear
  logic [31:0]    wdata;    // Write data
  logic [NST-1:0] status;   // Interrupt status
  logic [NST-1:0] int_en;   // Interrupt enables
  logic [NEV-1:0] event_v;  // New or snapshot events
  logic [NEV-1:0] evt_en;   // Event enables
  logic           irq;      // Interrupt level
  modport core (output evt, stat_rd, stat_wr, set_wr, inten_wr,
                evten_wr, evt_wr, wdata,
                input status, int_en, event_v, evt_en, irq);
  modport intr (input evt, stat_rd, stat_wr, set_wr, inten_wr,
                evten_wr, evt_wr, wdata,
                output status, int_en, event_v, evt_en, irq);
endinterface
`default_nettype wire

/* File: i2cerr_sync.sv */
/*
  Two-flop synchroniser for bus pins.
  Assumes inputs are asynchronous to hclk.
*/
`default_nettype none
module i2cerr_sync #(parameter int W = 2) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by s2
    logic [W-1:0] s2;  // Second stage
  } i2cerr_sy_type;
  i2cerr_sy_type st_r, st_nxt;

  // Shift the pins through both stages
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Idle bus level is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_r <= '1;
    else          st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule // i2cerr_sync
`default_nettype wire

/* File: i2cerr_irq.sv */
/*
  New-event, snapshot and status logic with one interrupt level.
  Assumes strobes from the core are single-cycle on hclk.
*/
`default_nettype none
module i2cerr_irq (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Core side
  i2cerr_evt_if.intr b
);
  import i2cerr_pkg::*;
  typedef struct packed {
    logic [NEV-1:0] new_ev;    // Events since last status read
    logic [NEV-1:0] snap;      // Snapshot taken on status read
    logic [NEV-1:0] evt_en;    // Event enables
    logic [NST-1:0] int_en;    // Interrupt enables
    logic           read_seen; // Status read since last clear
    logic           irq;       // Registered interrupt
  } i2cerr_iq_type;
  i2cerr_iq_type  st_r, st_nxt;
  logic [NEV-1:0] ev_act;
  logic [NEV-1:0] clr_m;
  logic [NEV-1:0] set_m;
  logic [NST-1:0] stat_v;

  // Event bookkeeping; hardware set always wins over clears
  always_comb begin
    st_nxt = st_r;
    ev_act = (st_r.new_ev | st_r.snap) & st_r.evt_en;
    clr_m  = '0;
    set_m  = '0;
    for (int s = 0; s < NST; s++) begin
      stat_v[s] = |(ev_act & EV_MAP[s]); // R10
      if (b.wdata[s]) begin
        clr_m = clr_m | EV_MAP[s];
        // Test set raises the first event of the group
        set_m = set_m | (EV_MAP[s] & (~EV_MAP[s] + 1'b1));
      end
    end
    // Snapshot: fold new events in, then empty the new register
    if (b.stat_rd) begin
      st_nxt.snap      = st_r.snap | st_r.new_ev; // R14
      st_nxt.new_ev    = '0; // R14
      st_nxt.read_seen = 1'b1;
    end
    // Clear acts on the snapshot only, so later events survive
    if (b.stat_wr) begin
      if (st_r.read_seen) begin // R11
        st_nxt.snap = st_r.snap & ~(clr_m & st_r.evt_en); // R13
      end
      st_nxt.read_seen = 1'b0;
    end
    // Direct event clear drops both copies
    if (b.evt_wr) begin
      st_nxt.snap   = st_nxt.snap & ~b.wdata[NEV-1:0];
      st_nxt.new_ev = st_nxt.new_ev & ~b.wdata[NEV-1:0];
    end
    if (b.evten_wr) st_nxt.evt_en = b.wdata[NEV-1:0];
    if (b.inten_wr) st_nxt.int_en = b.wdata[NST-1:0];
    st_nxt.new_ev = st_nxt.new_ev | b.evt; // R10
    if (b.set_wr) st_nxt.new_ev = st_nxt.new_ev | set_m; // R12
    st_nxt.irq = |(stat_v & st_r.int_en); // R10
  end

  // All event enables set at reset, interrupts masked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= '0;
      st_r.evt_en <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign b.status  = stat_v;
  assign b.int_en  = st_r.int_en;
  assign b.event_v = st_r.new_ev | st_r.snap;
  assign b.evt_en  = st_r.evt_en;
  assign b.irq     = st_r.irq;
endmodule // i2cerr_irq
`default_nettype wire

/* File: i2cerr_props.sv */
/* Port checker for i2cerr_top, one hclk domain.
   Assumes a bind from the bench top file. */
`default_nettype none
module i2cerr_props (
  input wire logic        hclk, hresetn, hreadyout, hresp, slv_req, slv_we, slv_wait,
  input wire logic        scl_oe, serial_data_line_oe, slv_rsp_valid, int_req, int_ack,
  input wire logic        bl_nack, bl_retry, bl_abort, bl_rec_valid, init_we,
  input wire logic [15:0] slv_addr, int_addr, bl_rec_addr, init_addr,
  input wire logic [31:0] slv_rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Fresh slave access aimed past the present blocks
  wire blk = slv_req && slv_addr[15:12] >= 4'h4 && !slv_wait && !int_req;
  AST_OKAY: assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_BLKV: assert property (blk |=> slv_rsp_valid && !int_req) else $error("no answer");
  AST_BLKZ: assert property (blk && !slv_we |=> slv_rsp_rdata == 32'h0) else $error("not 0");
  // Released lines are checked one cycle into the wait; the oe flops drop on the same edge as slv_wait
  AST_WAIT: assert property (slv_wait && $past(slv_wait) |-> !scl_oe && !serial_data_line_oe)
    else $error("lines held");
  AST_HOLD: assert property (int_req && !int_ack |=> int_req && $stable(int_addr))
    else $error("req dropped");
  AST_ACKR: assert property (int_req && int_ack |=> !int_req ##0 slv_rsp_valid)
    else $error("no reply");
  AST_RTRY: assert property (bl_retry |-> $past(bl_nack)) else $error("stray retry");
  AST_RECD: assert property (bl_rec_valid && bl_rec_addr[15:12] >= 4'h4 |=> !init_we)
    else $error("record kept");
  cover property (slv_wait);
  cover property (bl_abort);
  cover property (int_ack);
endmodule // i2cerr_props
`default_nettype wire

/* File: i2cerr_rtgt.sv */
/* Internal register target: acks int_req after three cycles.
   Assumes int_req holds until int_ack. */
`default_nettype none
module i2cerr_rtgt (
  input wire logic  hclk, int_req,
  output logic        int_ack,
  output logic [31:0] int_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;  // Cycles waited
  initial {int_ack, int_rdata, wait_r} = '0;
  // Idle data toggles, so data taken an odd number of cycles off the ack never matches
  always @(posedge hclk) begin
    wait_r <= (int_req && !int_ack) ? wait_r + 2'h1 : 2'h0;
    int_ack <= int_req && !int_ack && wait_r == 2'h2;
    int_rdata <= (int_req && wait_r == 2'h2) ? 32'hA5C31E70 : ~int_rdata;
  end
endmodule // i2cerr_rtgt
`default_nettype wire

/* File: i2c_error_and_interrupt_logic_tb.sv */
/* Bench for i2cerr_top: AHB-Lite, slave engine and loader.
   Assumes i2cerr_rtgt serves the internal port. */
`default_nettype none
module i2c_error_and_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import i2cerr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, scl_in, serial_data_line_in, scl_m, sda_m, irq;
  logic slv_active, slv_byte_active, slv_drive_phase, slv_sda_low, slv_scl_hold, slv_req, slv_we;
  logic bl_start, bl_arb_won, bl_nack, bl_size_valid, bl_two_byte, bl_cnt_valid, bl_proto_err;
  logic bl_rec_valid, bl_done, hreadyout, hresp, scl_oe, serial_data_line_oe, slv_rsp_valid;
  logic slv_wait, int_req, int_we, int_ack, bl_retry, bl_abort, init_we;
  logic [1:0] htrans;
  logic [2:0] hsize, bl_cnt_idx;
  logic [7:0] bl_cnt_byte;
  logic [15:0] slv_addr, bl_size, bl_rec_addr, int_addr, init_addr;
  logic [31:0] haddr, hwdata, hrdata, slv_wdata, slv_rsp_rdata, int_wdata, int_rdata;
  logic [31:0] bl_rec_data, init_data;
  int n_errors, samples_checked, nr;
  assign hready = hreadyout;
  // Open-drain wires: low while anyone pulls
  assign scl_in = scl_m && !scl_oe;
  assign serial_data_line_in = sda_m && !serial_data_line_oe;
  i2cerr_top #(.BOOT_TMO_CYCLES(50)) i_dut (.*);
  i2cerr_rtgt i_tgt (.*);
  initial begin hclk = 1'b0; forever #5 hclk = ~hclk; end
  initial begin #300us; n_errors++; end_of_test; end
  always @(posedge hclk) nr <= nr + (bl_retry === 1'b1);
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin n_errors++; $display("ERROR %0t got %h want %h", $time, s, e); end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Single word transfer; read data taken at the data phase's ready edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    repeat (3) @(posedge hclk);
    {hsel, haddr, hwrite, hsize, htrans} <= {1'b1, 24'h0, a, w, 3'h2, 2'h2};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {3'b0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) chk(hrdata, e);
  endtask
  task automatic sreq(input logic w, input logic [15:0] a, input logic [31:0] d, e);
    @(posedge hclk) {slv_req, slv_we, slv_addr, slv_wdata} <= {1'b1, w, a, d};
    @(posedge hclk) slv_req <= 1'b0;
    repeat (20) if (slv_rsp_valid !== 1'b1) @(posedge hclk);
    if (!w) chk(slv_rsp_rdata, e);
  endtask
  // One load: 0 never wins the bus, 1 six nacks, 2 size, 3 count byte, 4 records
  task automatic boot(input int k, input logic [31:0] e);
    ahb(1, A_EVT, 32'h7FF, 0);
    @(posedge hclk) bl_start <= 1'b1;
    @(posedge hclk) {bl_start, bl_arb_won} <= {1'b0, k != 0};
    @(posedge hclk) {bl_arb_won, bl_nack, bl_size_valid, bl_cnt_valid, bl_rec_valid} <=
      {1'b0, k == 1, k == 2, k == 3, k == 4};
    @(posedge hclk) {bl_size_valid, bl_cnt_valid, bl_rec_addr} <= {2'b0, 16'h0010};
    repeat (5) @(posedge hclk);
    {bl_nack, bl_rec_valid, bl_rec_addr} <= {2'b0, 16'h5000};
    repeat (60) @(posedge hclk);
    ahb(0, A_EVT, 0, e);
  endtask
  initial begin
    {hresetn, hsel, hwrite, slv_active, slv_byte_active, slv_drive_phase, slv_sda_low} = '0;
    {slv_scl_hold, slv_req, slv_we, bl_start, bl_arb_won, bl_nack, bl_size_valid} = '0;
    {bl_two_byte, bl_cnt_valid, bl_proto_err, bl_rec_valid, bl_done, htrans, hsize} = '0;
    {haddr, hwdata, slv_addr, slv_wdata, n_errors, samples_checked, nr} = '0;
    {scl_m, sda_m, bl_cnt_idx, bl_cnt_byte, bl_size} = {2'b11, 3'h2, 8'hFE, 16'h0100};
    {bl_rec_addr, bl_rec_data} = {16'h5000, 32'hC0DE0001};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, A_CTRL, 0, 1);
    ahb(0, 8'hF0, 0, 0);
    sreq(0, 16'h5000, 0, 0);
    sreq(0, 16'h1004, 0, 32'hA5C31E70);
    ahb(1, A_CTRL, 0, 0);
    sreq(0, 16'h1004, 0, 32'hA5C31E70);
    sreq(1, 16'h1008, 32'h1234ABCD, 0);
    ahb(0, A_WDATA, 0, 32'h1234ABCD);
    ahb(0, A_STAT, 0, 3);
    ahb(1, A_STAT, 5'h1F, 0);
    ahb(1, A_INTEN, 5'h1F, 0);
    ahb(1, A_TLOW, 5, 0);
    {slv_active, scl_m} <= 2'b10;
    repeat (20) @(posedge hclk);
    chk(slv_wait, 1);
    {slv_active, scl_m, sda_m} <= 3'b010;
    repeat (4) @(posedge hclk);
    sda_m <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(slv_wait, 0);
    ahb(0, A_STAT, 0, 8);
    chk(irq, 1);
    ahb(1, A_STAT, 8, 0);
    ahb(1, A_STAT, 8, 0);
    ahb(1, A_ISET, 8, 0);
    ahb(1, A_STAT, 8, 0);
    ahb(0, A_STAT, 0, 8);
    ahb(1, A_ISET, 8, 0);
    ahb(1, A_STAT, 8, 0);
    ahb(0, A_STAT, 0, 8);
    ahb(1, A_STAT, 8, 0);
    ahb(0, A_STAT, 0, 0);
    chk(irq, 0);
    boot(0, 32'h1 << EV_BOOTTO);
    boot(1, 32'h1 << EV_NODEV);
    chk(nr, 5);
    boot(2, 32'h1 << EV_SIZE);
    boot(3, 32'h1 << EV_PROTO);
    boot(4, 0);
    end_of_test;
  end
endmodule // i2c_error_and_interrupt_logic_tb
bind i2cerr_top i2cerr_props i_chk (.*);
`default_nettype wire
